// ==== bench/vpw_bus_model.sv ====
// Behavioural transceiver and bus seen by the VPW codec.
// Assumes one clock; the bus is wired-OR, active high, pulled passive.
`timescale 1ns/100ps

module vpw_bus_model #(
   parameter int TICK_CYCLES = 2
) (
   input  wire logic       core_clk,
   input  wire logic [4:0] loop_dly,
   input  wire logic       inv,
   input  wire logic       node_out,
   input  wire logic       other_drive,
   output logic            bus_level,
   output logic            serial_in
);
   logic [127:0] line_q;

   initial line_q = '0;

   // ----------------------------------------
   // Echo path with external loop delay
   // ----------------------------------------
   always @(posedge core_clk) begin
      line_q <= {line_q[126:0], node_out};
   end

   // ----------------------------------------
   // Wired-OR bus and receiver polarity
   // ----------------------------------------
   always_comb begin
      bus_level = other_drive | ((loop_dly == 5'h00) ? node_out : line_q[loop_dly * TICK_CYCLES - 1]);
      serial_in = bus_level ^ inv;
   end
endmodule : vpw_bus_model

// ==== bench/vpw_symbol_codec_bench.sv ====
// Self-checking bench for the VPW symbol codec.
// Assumes the bus model echoes the serial output; the tick is cut to 2 clocks.
`timescale 1ns/100ps
`include "vpw_symbol_codec_map.svh"

module vpw_symbol_codec_bench;
   import vpw_codec_pkg::*;
   localparam int TC = 2;
   localparam int TKS [15] = '{200, 64, 64, 128, 128, 94, 99, 161, 20, 150, 300, 200, 166, 64, 32};
   localparam int CDS [15] = '{4, 2, 3, 3, 2, 2, 2, 3, 1, 3, 7, 5, 4, 2, 1};
   typedef struct {logic [7:0] exp; logic [7:0] msk;} note_t;

   logic       core_clk    = 1'b0;
   logic       rst         = 1'b1;
   reg_req_t   reg_req     = '0;
   logic [7:0] reg_rdata;
   logic       bus_serial_in;
   logic       bus_serial_out;
   logic       bus_level;
   logic [4:0] loop_dly    = 5'h00;
   logic       inv         = 1'b0;
   logic       other_drive = 1'b0;
   logic       rd_seen     = 1'b0;
   logic       last_lvl    = 1'b0;
   int         run_len     = 0;
   int         bad_count   = 0;
   int         check_count = 0;
   note_t      rq[$];
   note_t      n_cur;
   int         wq[$];

   always #5 core_clk = ~core_clk;

   vpw_symbol_codec #(.TICK_CYCLES(TC)) i_dut (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .bus_serial_in(bus_serial_in), .bus_serial_out(bus_serial_out));
   vpw_bus_model #(.TICK_CYCLES(TC)) i_bus (.core_clk(core_clk), .loop_dly(loop_dly), .inv(inv),
      .node_out(bus_serial_out), .other_drive(other_drive), .bus_level(bus_level), .serial_in(bus_serial_in));

   // ----------------------------------------
   // Compare tasks and closing
   // ----------------------------------------
   task automatic fail(input logic [31:0] got, input logic [31:0] exp);
      bad_count++;
      $display("ERROR at %0t got %0h expected %0h", $time, got, exp);
   endtask : fail

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
      check_count++;
      if ((got & msk) !== exp) fail(got, exp);
   endtask : cmp8

   task automatic cmp_b(input logic got, input logic exp);
      @(negedge core_clk);
      check_count++;
      if (got !== exp) fail(got, exp);
   endtask : cmp_b

   task automatic cmp_w(input int got, input int exp);
      check_count++;
      if (got < exp - 3 || got > exp + 3) fail(got, exp);
   endtask : cmp_w

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // Register port and timing helpers
   // ----------------------------------------
   task automatic tk(input int n);
      repeat (n * TC) @(posedge core_clk);
   endtask : tk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      reg_req <= '0;
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge core_clk);
      rq.push_back('{exp: e, msk: m});
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      reg_req <= '0;
   endtask : rd

   task automatic rdn(input logic [2:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      reg_req <= '0;
      @(negedge core_clk);
      v = reg_rdata;
   endtask : rdn

   task automatic wait_st(input int b, input logic val);
      logic [7:0] v;
      for (int i = 0; i < 3000; i++) begin
         rdn(`VPW_REG_STATUS, v);
         if (v[b] === val) return;
      end
      fail(v, val);
   endtask : wait_st

   task automatic send(input tx_sym_t s);
      wait_st(`VPW_ST_PEND, 1'b0);
      wr(`VPW_REG_TXSYM, {5'h00, s});
   endtask : send

   // ----------------------------------------
   // Result watchers
   // ----------------------------------------
   always @(negedge core_clk) begin
      if (rd_seen && rq.size() > 0) begin
         n_cur = rq.pop_front();
         cmp8(reg_rdata, n_cur.exp, n_cur.msk);
      end
   end

   always @(posedge core_clk) begin
      rd_seen <= reg_req.rd;
      run_len++;
      if (bus_level !== last_lvl) begin
         if (run_len <= 250 * TC && wq.size() > 0) cmp_w(run_len / TC, wq.pop_front());
         run_len = 0;
         last_lvl = bus_level;
      end
   end

   initial begin
      repeat (80000) @(posedge core_clk);
      bad_count++;
      $display("ERROR at %0t watchdog expired", $time);
      end_sim();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [7:0] v;
      logic [7:0] byte_v;
      void'($urandom(32'h2646));
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rd(`VPW_REG_CTRL, 8'h00, 8'hff);
      rd(`VPW_REG_STATUS, 8'h08, 8'hff);
      rd(3'h5, 8'h00, 8'hff);
      rd(3'h7, 8'h00, 8'hff);
      cmp_b(bus_serial_out, 1'b0);
      v = {1'($urandom), 2'b00, 5'($urandom)};
      wr(`VPW_REG_CTRL, v);
      rd(`VPW_REG_CTRL, v, 8'h9f);
      wr(`VPW_REG_CTRL, 8'h00);
      tk(20);
      $display("test reset done");

      for (int i = 0; i < 15; i++) begin
         other_drive <= (i % 2 == 0);
         repeat (10 * TC - 2) @(posedge core_clk);
         if (i > 0) rd(`VPW_REG_LASTSYM, 8'(CDS[i-1]), 8'h07);
         if (i == 13) begin
            tk(30);
            other_drive <= 1'b1;
            tk(5);
            other_drive <= 1'b0;
            tk(19);
         end else begin
            tk(TKS[i] - 10);
         end
         if (i == 10) rd(`VPW_REG_STATUS, 8'h41, 8'h41);
      end
      other_drive <= 1'b0;
      repeat (10 * TC - 2) @(posedge core_clk);
      rd(`VPW_REG_LASTSYM, 8'h01, 8'h07);
      tk(320);
      rd(`VPW_REG_LASTSYM, 8'h06, 8'h07);
      rd(`VPW_REG_STATUS, 8'h08, 8'h48);
      wr(`VPW_REG_STATUS, 8'h07);
      rd(`VPW_REG_STATUS, 8'h00, 8'h07);
      $display("test receive done");

      for (int k = 0; k < 2; k++) begin
         v = {1'(k), 2'b00, (k == 0) ? 5'h00 : 5'($urandom)};
         wr(`VPW_REG_CTRL, v);
         inv <= v[7];
         loop_dly <= v[4:0];
         byte_v = 8'($urandom);
         wq.push_back(200);
         send(TX_SOF);
         for (int j = 0; j < 8; j++) begin
            wq.push_back((byte_v[7-j] ^ j[0]) ? 128 : 64);
            send(byte_v[7-j] ? TX_BIT1 : TX_BIT0);
         end
         wq.push_back(200);
         send(TX_EOD);
         wq.push_back((k == 0) ? 64 : 128);
         send((k == 0) ? TX_NB_SHORT : TX_NB_LONG);
         wait_st(`VPW_ST_IDLE, 1'b1);
         cmp_b(bus_serial_out, 1'b0);
         rd(`VPW_REG_STATUS, 8'h02, 8'h12);
         rd(`VPW_REG_RXDATA, byte_v, 8'hff);
         rd(`VPW_REG_STATUS, 8'h00, 8'h02);
         $display("test transmit %0d done", k);
      end

      send(TX_SOF);
      send(TX_BIT1);
      send(TX_BIT0);
      for (int n = 0; n < 2000 && bus_level !== 1'b0; n++) @(posedge core_clk);
      tk(64);
      other_drive <= 1'b1;
      tk(20);
      rd(`VPW_REG_STATUS, 8'h04, 8'h24);
      tk(100);
      cmp_b(bus_serial_out, 1'b0);
      other_drive <= 1'b0;
      tk(320);
      wr(`VPW_REG_STATUS, 8'h07);
      rd(`VPW_REG_STATUS, 8'h00, 8'h07);
      tk(2);
      $display("test arbitration done");
      end_sim();
   end
endmodule : vpw_symbol_codec_bench

// ==== src/vpw_codec_pkg.sv ====
// Types shared by the VPW symbol codec.
// Assumes the map header supplies the register address width.
`include "vpw_symbol_codec_map.svh"

package vpw_codec_pkg;

   // Symbols that software queues for sending
   typedef enum logic [2:0] {
      TX_BIT0, TX_BIT1, TX_SOF, TX_EOD, TX_EOF, TX_NB_SHORT, TX_NB_LONG, TX_BRK
   } tx_sym_t;

   // Symbols that the decoder recognises
   typedef enum logic [2:0] {
      RX_NONE, RX_INVALID, RX_ZERO, RX_ONE, RX_SOF, RX_EOD, RX_EOF, RX_BRK
   } rx_sym_t;

   typedef enum logic [1:0] {
      TXS_IDLE, TXS_WAIT, TXS_HOLD
   } tx_state_t;

   // Register port request
   typedef struct packed {
      logic [`VPW_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
      logic                   wr;
      logic                   rd;
   } reg_req_t;

endpackage : vpw_codec_pkg

// ==== src/vpw_symbol_codec.sv ====
// VPW symbol encoder and decoder with digital filter and loop delay compensation.
// Assumes an external transceiver echoes bus_serial_out back onto bus_serial_in.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "vpw_symbol_codec_map.svh"

module vpw_symbol_codec #(
   parameter int TICK_CYCLES = `VPW_TICK_CYCLES
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire vpw_codec_pkg::reg_req_t reg_req,
   output logic [7:0]                 reg_rdata,
   input  wire logic                  bus_serial_in,
   output logic                       bus_serial_out
);
   import vpw_codec_pkg::*;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   logic [PW-1:0] pre_cnt_q;
   logic          tick;
   logic          in_s1_q;
   logic          in_s2_q;
   logic          rx_raw;
   logic          filt_q;
   logic [3:0]    pulse_cnt_q;
   logic [8:0]    sym_cnt_q;
   logic [8:0]    dur;
   logic          edge_acc;
   rx_sym_t       rx_sym;
   rx_sym_t       last_sym_q;
   logic          eof_evt;
   logic          idle_evt;
   logic          bus_idle_q;
   logic          mute_q;
   logic [2:0]    bit_cnt_q;
   logic [7:0]    shift_q;
   logic [7:0]    rx_data_q;
   logic          is_bit;
   logic          byte_done;
   logic          invalid_evt;
   logic          invert_q;
   logic [4:0]    loop_delay_setting;
   logic          invalid_bit_flag;
   logic          receive_full_flag;
   logic          arb_lost_q;
   tx_state_t     tx_state_q;
   tx_sym_t       tx_sym_q;
   logic          tx_lvl_q;
   logic [8:0]    tx_target_q;
   logic          pend_v_q;
   tx_sym_t       pend_sym_q;
   logic          out_q;
   logic          arb_evt;
   logic          hold_done;
   logic          wr_ctrl;
   logic          wr_tx;
   logic          wr_stat;
   logic          rd_rx;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic rx_sym_t classify(input logic lvl, input logic [8:0] d);
      rx_sym_t s;
      s = RX_NONE;
      if (d <= `VPW_IGNORE_MAX) begin
         s = RX_NONE;
      end else if (d <= `VPW_INVALID_MAX) begin
         s = RX_INVALID;
      end else if (d <= `VPW_TV1_MAX) begin
         s = lvl ? RX_ONE : RX_ZERO;
      end else if (d <= `VPW_TV2_MAX) begin
         s = lvl ? RX_ZERO : RX_ONE;
      end else if (d <= `VPW_TV3_MAX) begin
         s = lvl ? RX_SOF : RX_EOD;
      end else begin
         s = lvl ? RX_BRK : RX_EOF;
      end
      return s;
   endfunction : classify

   function automatic logic sym_level(input tx_sym_t s, input logic cur);
      logic l;
      l = 1'b1;
      if (s == TX_BIT0 || s == TX_BIT1) begin
         l = ~cur;
      end else if (s == TX_EOD || s == TX_EOF) begin
         l = 1'b0;
      end
      return l;
   endfunction : sym_level

   function automatic logic [8:0] sym_nominal(input tx_sym_t s, input logic l);
      logic [8:0] n;
      n = `VPW_TV1_NOM;
      case (s)
         TX_BIT0:     n = l ? `VPW_TV2_NOM : `VPW_TV1_NOM;
         TX_BIT1:     n = l ? `VPW_TV1_NOM : `VPW_TV2_NOM;
         TX_SOF:      n = `VPW_TV3_NOM;
         TX_EOD:      n = `VPW_TV3_NOM;
         TX_EOF:      n = `VPW_TV4_NOM;
         TX_NB_SHORT: n = `VPW_TV1_NOM;
         TX_NB_LONG:  n = `VPW_TV2_NOM;
         TX_BRK:      n = `VPW_TV5_NOM;
         default:     n = `VPW_TV1_NOM;
      endcase
      return n;
   endfunction : sym_nominal

   // ----------------------------------------
   // Time base and input path
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pre_cnt_q <= '0;
      end else if (pre_cnt_q == PW'(TICK_CYCLES - 1)) begin
         pre_cnt_q <= '0;
      end else begin
         pre_cnt_q <= pre_cnt_q + 1'b1;
      end
   end
   assign tick = (pre_cnt_q == PW'(TICK_CYCLES - 1));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_s1_q <= 1'b0;
         in_s2_q <= 1'b0;
      end else begin
         in_s1_q <= bus_serial_in;
         in_s2_q <= in_s1_q;
      end
   end
   assign rx_raw = in_s2_q ^ invert_q;

   // ----------------------------------------
   // Digital filter and symbol counter
   // ----------------------------------------
   assign edge_acc = (rx_raw != filt_q) && tick && (pulse_cnt_q == `VPW_FILT_LAST);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         filt_q      <= 1'b0;
         pulse_cnt_q <= 4'h0;
      end else if (rx_raw == filt_q) begin
         pulse_cnt_q <= 4'h0;
      end else if (edge_acc) begin
         filt_q      <= rx_raw;
         pulse_cnt_q <= 4'h0;
      end else if (tick) begin
         pulse_cnt_q <= pulse_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sym_cnt_q <= `VPW_CNT_MAX;
      end else if (edge_acc) begin
         sym_cnt_q <= `VPW_FILT_TICKS;
      end else if (tick && sym_cnt_q != `VPW_CNT_MAX) begin
         sym_cnt_q <= sym_cnt_q + 9'd1;
      end
   end

   assign dur         = sym_cnt_q - `VPW_DUR_ADJ;
   assign rx_sym      = edge_acc ? classify(filt_q, dur) : RX_NONE;
   assign eof_evt     = !filt_q && tick && sym_cnt_q == `VPW_TV3_MAX;
   assign idle_evt    = !filt_q && tick && sym_cnt_q == `VPW_TV6_NOM;
   assign invalid_evt = (rx_sym == RX_INVALID);
   assign is_bit      = (rx_sym == RX_ZERO || rx_sym == RX_ONE) && last_sym_q != RX_EOD;
   assign byte_done   = is_bit && bit_cnt_q == 3'd7;

   // ----------------------------------------
   // Receive framing
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_idle_q <= 1'b1;
      end else if (edge_acc) begin
         bus_idle_q <= 1'b0;
      end else if (idle_evt) begin
         bus_idle_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mute_q     <= 1'b0;
         bit_cnt_q  <= 3'd0;
         shift_q    <= 8'h00;
         rx_data_q  <= 8'h00;
         last_sym_q <= RX_NONE;
      end else if (eof_evt) begin
         mute_q     <= 1'b0;
         bit_cnt_q  <= 3'd0;
         last_sym_q <= RX_EOF;
      end else if (edge_acc) begin
         last_sym_q <= rx_sym;
         if (invalid_evt) begin
            mute_q    <= 1'b1;
            bit_cnt_q <= 3'd0;
         end else if (is_bit) begin
            shift_q   <= {shift_q[6:0], rx_sym == RX_ONE};
            bit_cnt_q <= bit_cnt_q + 3'd1;
            if (byte_done && !mute_q) begin
               rx_data_q <= {shift_q[6:0], rx_sym == RX_ONE};
            end
         end else if (rx_sym != RX_NONE) begin
            bit_cnt_q <= 3'd0;
         end
      end
   end

   // ----------------------------------------
   // Register port decode
   // ----------------------------------------
   assign wr_ctrl = reg_req.wr && reg_req.addr == `VPW_REG_CTRL;
   assign wr_tx   = reg_req.wr && reg_req.addr == `VPW_REG_TXSYM;
   assign wr_stat = reg_req.wr && reg_req.addr == `VPW_REG_STATUS;
   assign rd_rx   = reg_req.rd && reg_req.addr == `VPW_REG_RXDATA;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         invert_q           <= 1'(`VPW_CTRL_RESET >> `VPW_CTRL_INV);
         loop_delay_setting <= 5'h00;
      end else if (wr_ctrl) begin
         invert_q           <= reg_req.wdata[`VPW_CTRL_INV];
         loop_delay_setting <= reg_req.wdata[`VPW_CTRL_DLY_MSB:0];
      end
   end

   // Flags: a hardware set wins over a clear in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         invalid_bit_flag  <= 1'b0;
         receive_full_flag <= 1'b0;
         arb_lost_q        <= 1'b0;
      end else begin
         if (invalid_evt) begin
            invalid_bit_flag <= 1'b1;
         end else if (wr_stat && reg_req.wdata[`VPW_ST_INVBIT]) begin
            invalid_bit_flag <= 1'b0;
         end
         if (byte_done && !mute_q) begin
            receive_full_flag <= 1'b1;
         end else if (rd_rx) begin
            receive_full_flag <= 1'b0;
         end
         if (arb_evt) begin
            arb_lost_q <= 1'b1;
         end else if (wr_stat && reg_req.wdata[`VPW_ST_ARB]) begin
            arb_lost_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (!reg_req.rd) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.addr == `VPW_REG_CTRL) begin
         reg_rdata <= {invert_q, 2'b00, loop_delay_setting};
      end else if (reg_req.addr == `VPW_REG_TXSYM) begin
         reg_rdata <= {4'h0, pend_v_q, pend_sym_q};
      end else if (reg_req.addr == `VPW_REG_STATUS) begin
         reg_rdata <= {filt_q, mute_q, pend_v_q, tx_state_q != TXS_IDLE, bus_idle_q,
                       arb_lost_q, receive_full_flag, invalid_bit_flag};
      end else if (reg_req.addr == `VPW_REG_RXDATA) begin
         reg_rdata <= rx_data_q;
      end else if (reg_req.addr == `VPW_REG_LASTSYM) begin
         reg_rdata <= {5'h00, last_sym_q};
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Encoder
   // ----------------------------------------
   assign arb_evt   = tx_state_q == TXS_HOLD && !tx_lvl_q && filt_q &&
                      (tx_sym_q == TX_BIT0 || tx_sym_q == TX_BIT1);
   assign hold_done = tx_state_q == TXS_HOLD && filt_q == tx_lvl_q &&
                      sym_cnt_q >= tx_target_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_state_q  <= TXS_IDLE;
         tx_sym_q    <= TX_BIT0;
         tx_lvl_q    <= 1'b0;
         tx_target_q <= `VPW_TV1_NOM;
         pend_v_q    <= 1'b0;
         pend_sym_q  <= TX_BIT0;
         out_q       <= 1'b0;
      end else if (invalid_evt) begin
         tx_state_q <= TXS_IDLE;
         out_q      <= 1'b0;
         pend_v_q   <= 1'b0;
      end else begin
         if (wr_tx && !pend_v_q) begin
            pend_v_q   <= 1'b1;
            pend_sym_q <= tx_sym_t'(reg_req.wdata[2:0]);
         end
         case (tx_state_q)
            TXS_IDLE: begin
               if (pend_v_q) begin
                  pend_v_q    <= 1'b0;
                  tx_sym_q    <= pend_sym_q;
                  tx_lvl_q    <= sym_level(pend_sym_q, out_q);
                  out_q       <= sym_level(pend_sym_q, out_q);
                  tx_target_q <= sym_nominal(pend_sym_q, sym_level(pend_sym_q, out_q)) -
                                 {4'h0, loop_delay_setting};
                  tx_state_q  <= TXS_WAIT;
               end else begin
                  out_q <= 1'b0;
               end
            end
            TXS_WAIT: begin
               if (filt_q == tx_lvl_q) begin
                  tx_state_q <= TXS_HOLD;
               end
            end
            TXS_HOLD: begin
               if (arb_evt) begin
                  out_q      <= 1'b0;
                  pend_v_q   <= 1'b0;
                  tx_state_q <= TXS_IDLE;
               end else if (hold_done && pend_v_q) begin
                  pend_v_q    <= 1'b0;
                  tx_sym_q    <= pend_sym_q;
                  tx_lvl_q    <= sym_level(pend_sym_q, out_q);
                  out_q       <= sym_level(pend_sym_q, out_q);
                  tx_target_q <= sym_nominal(pend_sym_q, sym_level(pend_sym_q, out_q)) -
                                 {4'h0, loop_delay_setting};
                  tx_state_q  <= TXS_WAIT;
               end else if (hold_done) begin
                  out_q      <= 1'b0;
                  tx_state_q <= TXS_IDLE;
               end
            end
            default: begin
               tx_state_q <= TXS_IDLE;
            end
         endcase
      end
   end

   assign bus_serial_out = out_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_idle_out_passive: assert property (tx_state_q == TXS_IDLE && !$past(pend_v_q) |-> !bus_serial_out)
      else $error("Output not passive while encoder idle");
   a_filter_width: assert property ($changed(filt_q) |-> $past(pulse_cnt_q) == 4'd7 && $past(tick))
      else $error("Filter changed without eight ticks of new level");
   a_glitch_no_resync: assert property (rx_raw != filt_q && tick && pulse_cnt_q < 4'd7
                                        |=> filt_q == $past(filt_q))
      else $error("Short pulse moved filtered level");
   a_resync_count: assert property ($changed(filt_q) |-> sym_cnt_q == 9'd8)
      else $error("Symbol counter not resynchronised on edge");
   a_invalid_flag: assert property (invalid_evt |=> invalid_bit_flag && mute_q && !bus_serial_out)
      else $error("Invalid bit not flagged or transmission not aborted");
   a_mute_no_full: assert property (mute_q && !receive_full_flag |=> !receive_full_flag)
      else $error("Receive full set while receive muted");
   a_arb_drop: assert property (arb_evt |=> !bus_serial_out && arb_lost_q && tx_state_q == TXS_IDLE)
      else $error("Output not released after lost arbitration");
   a_hold_time: assert property ($past(tx_state_q == TXS_HOLD) && tx_state_q != TXS_HOLD
                                 && !$past(arb_evt) && !$past(invalid_evt)
                                 |-> $past(sym_cnt_q) >= $past(tx_target_q))
      else $error("Symbol released before its nominal length");
   a_end_passive: assert property (hold_done && !pend_v_q && !invalid_evt
                                   |=> !bus_serial_out && tx_state_q == TXS_IDLE)
      else $error("Output not passive after last symbol");
   a_idle_detect: assert property (idle_evt && !edge_acc |=> bus_idle_q)
      else $error("Long passive level not reported idle");

   c_byte_received: cover property (byte_done && !mute_q);
   c_arb_lost: cover property (arb_evt);
   c_back_to_back: cover property (hold_done && pend_v_q);
   c_invalid_seen: cover property (invalid_evt);

endmodule : vpw_symbol_codec

// ==== src/vpw_symbol_codec_map.svh ====
// Register offsets, field positions, reset values and symbol timing for the VPW codec.
// Assumes a 100 MHz core clock and a one microsecond symbol time base.
// Operation
// - Serial output low when idle, high active
// - One transition per symbol, timed between edges
// - Zero/one bits use Tv1/Tv2 by level
// - Bytes are eight bits, passive first
// - SOF active Tv3, EOD passive Tv3
// - EOF passive Tv4, IFS passive Tv6
// - Passive beyond Tv6 means bus idle
// - Normalization active Tv1/Tv2, break active Tv5
// - Up to 7 ignored, up to 34 invalid
// - Tv1 35..96, Tv2 97..163 accepted
// - Tv3 164..239, Tv4/Tv5 above 239
// - Ignored pulses never resync symbol counter
// - Invalid bit resyncs timing to its edges
// - Invalid bit flags, aborts, mutes receive until EOF
// - Control bit selects input polarity
// - Five bit loop delay, 0..31 us
// - Wait for echo, hold for nominal length
// - Lost arbitration forces output passive at once
// - Toggle at symbol end only if more queued
// - Always time output from decoder output
`ifndef VPW_SYMBOL_CODEC_MAP_SVH
`define VPW_SYMBOL_CODEC_MAP_SVH

// ----------------------------------------
// Time base
// ----------------------------------------
`define VPW_CLK_PERIOD_NS 10
`define VPW_TICK_NS       1000
`define VPW_TICK_CYCLES   ((`VPW_TICK_NS) / (`VPW_CLK_PERIOD_NS))

// ----------------------------------------
// Symbol widths in ticks
// ----------------------------------------
`define VPW_IGNORE_MAX   9'd7
`define VPW_INVALID_MAX  9'd34
`define VPW_TV1_MAX      9'd96
`define VPW_TV2_MAX      9'd163
`define VPW_TV3_MAX      9'd239
`define VPW_TV1_NOM      9'd64
`define VPW_TV2_NOM      9'd128
`define VPW_TV3_NOM      9'd200
`define VPW_TV4_NOM      9'd280
`define VPW_TV5_NOM      9'd300
`define VPW_TV6_NOM      9'd300
`define VPW_CNT_MAX      9'h1ff
`define VPW_FILT_LAST    4'd7
`define VPW_FILT_TICKS   9'd8
`define VPW_DUR_ADJ      9'd7

// ----------------------------------------
// Register map
// ----------------------------------------
`define VPW_ADDR_W       3
`define VPW_REG_CTRL     3'h0
`define VPW_REG_TXSYM    3'h1
`define VPW_REG_STATUS   3'h2
`define VPW_REG_RXDATA   3'h3
`define VPW_REG_LASTSYM  3'h4
`define VPW_CTRL_INV     7
`define VPW_CTRL_DLY_MSB 4
`define VPW_CTRL_RESET   8'h00
`define VPW_ST_INVBIT    0
`define VPW_ST_RXF       1
`define VPW_ST_ARB       2
`define VPW_ST_IDLE      3
`define VPW_ST_BUSY      4
`define VPW_ST_PEND      5
`define VPW_ST_MUTE      6
`define VPW_ST_LEVEL     7

`endif
